// file: common/header_gpio_pkg.sv
// Package for the header GPIO direction port: register offsets, reset values, bus carriers.
// Assumes a 32-bit APB with word-aligned byte addresses.
package header_gpio_pkg;
	// Register byte offsets
	localparam logic [11:0] off_header_data_first_set = 12'h000; // First set data
	localparam logic [11:0] off_header_direction_first_set = 12'h004; // First set direction
	localparam logic [11:0] off_header_data_second_set = 12'h008; // Second set data
	localparam logic [11:0] off_header_direction_second_set = 12'h00c; // Second set direction
	localparam logic [11:0] off_module_header_data = 12'h010; // Module header data
	localparam logic [11:0] off_module_header_direction = 12'h014; // Module header direction
	// Reset values
	localparam logic [31:0] rst_data = 32'h00000000; // Output latches clear
	localparam logic [31:0] rst_direction = 32'hffffffff; // All pins input
	// APB request carrier
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;
	// Pin group carrier
	typedef struct packed {
		logic [31:0] out;
		logic [31:0] oe;
	} pin_drive_s;
endpackage

// file: core/header_gpio_direction_port.sv
// Header GPIO direction port: three groups of 32 pins, each with data and direction registers.
// Assumes an APB master on clk and pin inputs asynchronous to clk.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module header_gpio_direction_port
	import header_gpio_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire apb_req_s apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] exp_a_in,
	output pin_drive_s exp_a_drv,
	input wire logic [31:0] exp_b_in,
	output pin_drive_s exp_b_drv,
	input wire logic [31:0] mod_in,
	output pin_drive_s mod_drv
);
	localparam int groups = 3; // Expansion set A, set B, module header

	// Pin inputs per group
	logic [31:0] pin_in [groups];
	assign pin_in[0] = exp_a_in;
	assign pin_in[1] = exp_b_in;
	assign pin_in[2] = mod_in;

	// Register state
	logic [31:0] data_reg [groups]; // Output latch per group
	logic [31:0] dir_reg [groups]; // Direction per group
	logic [31:0] sync1 [groups]; // First sync stage
	logic [31:0] sync2 [groups]; // Second sync stage
	logic [31:0] next_data_reg [groups];
	logic [31:0] next_dir_reg [groups];
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// Access decode
	logic setup;
	logic hit;
	logic [2:0] sel_group;
	logic sel_dir;
	assign setup = apb_req.psel && !apb_req.penable;

	// Address decode into group and register kind
	// Groups 0 and 1 form the expansion header, group 2 the module header
	// Any other word misses and is answered with an error, never a write
	always_comb begin
		hit = 1'b1;
		sel_group = 3'h0;
		sel_dir = 1'b0;
		unique case (apb_req.paddr)
			off_header_data_first_set: sel_group = 3'h0;
			off_header_direction_first_set: sel_dir = 1'b1;
			off_header_data_second_set: sel_group = 3'h1;
			off_header_direction_second_set: begin
				sel_group = 3'h1;
				sel_dir = 1'b1;
			end
			off_module_header_data: sel_group = 3'h2;
			off_module_header_direction: begin
				sel_group = 3'h2;
				sel_dir = 1'b1;
			end
			default: hit = 1'b0; // Unmapped
		endcase
	end

	// Next register state; write at access phase end, readback per bit
	// Writes land only at the edge where pready is seen in the access phase
	// Read data is built at setup so that it stands in the access cycle
	always_comb begin
		next_pready = setup; // One wait-free access cycle after setup
		next_pslverr = setup && !hit;
		next_prdata = 32'h00000000;
		for (int g = 0; g < groups; g++) begin
			next_data_reg[g] = data_reg[g];
			next_dir_reg[g] = dir_reg[g];
		end
		if (apb_req.psel && apb_req.penable && pready && apb_req.pwrite && hit) begin
			for (int g = 0; g < groups; g++) begin
				if (sel_group == 3'(g)) begin
					if (sel_dir) begin
						next_dir_reg[g] = apb_req.pwdata;
					end else begin
						next_data_reg[g] = apb_req.pwdata;
					end
				end
			end
		end
		if (setup && !apb_req.pwrite && hit) begin
			for (int g = 0; g < groups; g++) begin
				if (sel_group == 3'(g)) begin
					if (sel_dir) begin
						next_prdata = dir_reg[g];
					end else begin
						// Input bits show the pin, output bits the latch
						next_prdata = (dir_reg[g] & sync2[g]) | (~dir_reg[g] & data_reg[g]);
					end
				end
			end
		end
	end

	// Register update
	// Pins pass sync1 and then sync2; only sync2 feeds the read mux
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int g = 0; g < groups; g++) begin
				data_reg[g] <= rst_data;
				dir_reg[g] <= rst_direction;
				sync1[g] <= 32'h00000000;
				sync2[g] <= 32'h00000000;
			end
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			for (int g = 0; g < groups; g++) begin
				data_reg[g] <= next_data_reg[g];
				dir_reg[g] <= next_dir_reg[g];
				sync1[g] <= pin_in[g];
				sync2[g] <= sync1[g];
			end
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Pin drivers registered from the latch and direction
	// Built from next values so the pins move at the same edge as the registers
	// Reset leaves every driver off so nothing fights an external device
	pin_drive_s drv [groups];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int g = 0; g < groups; g++) begin
				drv[g] <= '{out: rst_data, oe: ~rst_direction};
			end
		end else begin
			for (int g = 0; g < groups; g++) begin
				drv[g] <= '{out: next_data_reg[g], oe: ~next_dir_reg[g]};
			end
		end
	end
	assign exp_a_drv = drv[0];
	assign exp_b_drv = drv[1];
	assign mod_drv = drv[2];

	// Checks
	// Reset leaves set A and module pins undriven, set B direction and module data at their reset values
	chk_reset_inputs: assert property (@(posedge clk) $fell(rst) |-> mod_drv.oe == 32'h0 && exp_a_drv.oe == 32'h0)
		else $error("pins driven after reset");
	chk_reset_regs: assert property (@(posedge clk) $fell(rst)
		|-> dir_reg[1] == rst_direction && data_reg[2] == rst_data)
		else $error("registers not at reset values");

	// Direction and drive checks
	chk_dir_oe: assert property (@(posedge clk) disable iff (rst) exp_a_drv.oe == ~dir_reg[0])
		else $error("oe disagrees with direction");
	chk_bit_map: assert property (@(posedge clk) disable iff (rst)
		(exp_b_drv.oe & ~(~dir_reg[1])) == 32'h0)
		else $error("bit mapping broken");
	chk_out_latch: assert property (@(posedge clk) disable iff (rst) mod_drv.out == data_reg[2])
		else $error("pin level not the latch");

	// Write path checks
	chk_write_drive: assert property (@(posedge clk) disable iff (rst)
		apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.paddr == off_module_header_data
		|=> mod_drv.out == $past(apb_req.pwdata))
		else $error("module data write not driven");
	chk_dir_write: assert property (@(posedge clk) disable iff (rst)
		apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.paddr == off_header_direction_first_set
		|=> dir_reg[0] == $past(apb_req.pwdata))
		else $error("direction write lost");
	chk_mod_dir: assert property (@(posedge clk) disable iff (rst)
		apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.paddr == off_module_header_direction
		|=> mod_drv.oe == ~$past(apb_req.pwdata))
		else $error("module direction write lost");
	// A refused write must leave the group 0 and group 2 registers alone
	chk_unmapped_write: assert property (@(posedge clk) disable iff (rst)
		apb_req.psel && apb_req.penable && pready && apb_req.pwrite && !hit
		|=> dir_reg[0] == $past(dir_reg[0]) && data_reg[0] == $past(data_reg[0])
			&& dir_reg[2] == $past(dir_reg[2]) && data_reg[2] == $past(data_reg[2]))
		else $error("unmapped write changed a register");

	// Read path checks
	chk_input_read: assert property (@(posedge clk) disable iff (rst)
		setup && !apb_req.pwrite && apb_req.paddr == off_header_data_second_set
		|=> prdata == ((dir_reg[1] & $past(sync2[1])) | (~dir_reg[1] & $past(data_reg[1]))))
		else $error("read data not pin level");
	// Module header readback: input bits show the synced pin, output bits the latch
	chk_mod_read_in: assert property (@(posedge clk) disable iff (rst)
		setup && !apb_req.pwrite && apb_req.paddr == off_module_header_data
		|=> (prdata & $past(dir_reg[2])) == ($past(sync2[2]) & $past(dir_reg[2])))
		else $error("input bit not pin level");
	chk_mod_read_out: assert property (@(posedge clk) disable iff (rst)
		setup && !apb_req.pwrite && apb_req.paddr == off_module_header_data
		|=> (prdata & ~$past(dir_reg[2])) == ($past(data_reg[2]) & ~$past(dir_reg[2])))
		else $error("output bit not latch level");

	// Bus answer checks
	chk_ready_one: assert property (@(posedge clk) disable iff (rst) setup |=> pready ##1 !pready)
		else $error("pready not one cycle");
	chk_ready_cause: assert property (@(posedge clk) disable iff (rst) pready |-> $past(setup))
		else $error("pready without setup");
	chk_err_answer: assert property (@(posedge clk) disable iff (rst) setup && !hit |=> pready && pslverr)
		else $error("unmapped word not refused");
	chk_err_data: assert property (@(posedge clk) disable iff (rst) pslverr |-> pready && prdata == 32'h00000000)
		else $error("refused read returned data");

	// Scenario covers
	cov_write: cover property (@(posedge clk) apb_req.pwrite && pready);
	cov_read: cover property (@(posedge clk) !apb_req.pwrite && pready && !pslverr);
	cov_err: cover property (@(posedge clk) pslverr);
	cov_mod_dir: cover property (@(posedge clk) apb_req.psel && apb_req.penable && pready && apb_req.pwrite
		&& apb_req.paddr == off_module_header_direction);
	cov_pin_change: cover property (@(posedge clk) disable iff (rst) sync2[0] != $past(sync2[0]));
endmodule // header_gpio_direction_port

// file: tb/header_pin_partner.sv
// Far-side model: devices wired to one group of header pins.
// Assumes the port's drive struct; undriven pins take the level the bench sets.
`timescale 1ns/1ps
module header_pin_partner
	import header_gpio_pkg::*;
(
	input wire pin_drive_s drv,
	input wire logic [31:0] ext,
	output logic [31:0] pin
);
	// Driven bits show the port's level, released bits the device's level
	assign pin = (drv.oe & drv.out) | (~drv.oe & ext);
endmodule // header_pin_partner

// file: tb/header_gpio_direction_port_tb.sv
// Bench for the header GPIO port: APB register access and per-bit pin control.
// Assumes the port answers in its own time and two sync edges on pin inputs.
`timescale 1ns/1ps
module header_gpio_direction_port_tb;
	import header_gpio_pkg::*;
	logic clk = 1'b0; // System clock
	logic rst = 1'b1; // Reset, active high
	apb_req_s apb_req = '0; // Bus request
	logic [31:0] prdata; // Read data
	logic pready; // Answer strobe
	logic pslverr; // Error flag
	logic [31:0] ext[3] = '{32'h3c3c5a5a, 32'h0f0f00ff, 32'h96969669}; // Device levels
	logic [31:0] pin[3]; // Wire levels
	pin_drive_s drv[3]; // Port drive
	int err_count = 0; // Mismatches
	int checks = 0; // Comparisons
	always #5 clk = ~clk;
	header_gpio_direction_port dut_u (.clk(clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exp_a_in(pin[0]), .exp_a_drv(drv[0]),
		.exp_b_in(pin[1]), .exp_b_drv(drv[1]), .mod_in(pin[2]), .mod_drv(drv[2]));
	// One far-side model per pin group
	for (genvar g = 0; g < 3; g++) begin : far_g
		header_pin_partner far_u (.drv(drv[g]), .ext(ext[g]), .pin(pin[g]));
	end
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1); // Only the watchdog ends a hung wait
		r = prdata;
		e = pslverr;
		apb_req <= '0;
	endtask
	// Reset state, direction, output drive and input sampling of one group
	task automatic grp_test(input int g, input logic [11:0] a);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a + 12'h004, '0, r, e);
		chk(r, rst_direction);
		chk(drv[g].oe, 32'h00000000);
		xfer(1'b0, a, '0, r, e);
		chk(r, ext[g]);
		xfer(1'b1, a + 12'h004, 32'h0000ffff, r, e);
		xfer(1'b1, a, 32'h12345678, r, e);
		repeat (2) @(posedge clk);
		chk(drv[g].oe, 32'hffff0000);
		chk(drv[g].out & drv[g].oe, 32'h12340000);
		ext[g] <= ~ext[g];
		repeat (4) @(posedge clk);
		xfer(1'b0, a, '0, r, e);
		chk(r, 32'h12340000 | (ext[g] & 32'h0000ffff));
		xfer(1'b0, a + 12'h004, '0, r, e);
		chk(r, 32'h0000ffff);
		$display("Group %0d test done", g);
	endtask
	// Unmapped word answers with an error and zero data
	task automatic unmapped_test;
		logic [31:0] r;
		logic e;
		xfer(1'b0, 12'h018, '0, r, e);
		chk({31'h0, e}, 32'h00000001);
		chk(r, 32'h00000000);
		@(posedge clk);
		chk({31'h0, pready}, 32'h00000000);
		xfer(1'b1, 12'h018, 32'hffffffff, r, e);
		chk({31'h0, e}, 32'h00000001);
		xfer(1'b0, off_header_direction_first_set, '0, r, e);
		chk(r, 32'h0000ffff);
		$display("Unmapped test done");
	endtask
	// Verdict and end of run
	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		grp_test(0, off_header_data_first_set);
		grp_test(1, off_header_data_second_set);
		grp_test(2, off_module_header_data);
		unmapped_test();
		end_of_test();
	end
	// Watchdog against a hung bus; the tests need about a hundred cycles
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule // header_gpio_direction_port_tb
